// *** design/sensor_cfg_pkg.sv ***
package sensor_cfg_pkg;

  // register addresses
  localparam logic [7:0] ADDR_SENSING_MODE_CONFIG  = 8'h70;
  localparam logic [7:0] ADDR_PHOTODIODE_PIN_ROUTE = 8'h73;
  localparam logic [7:0] ADDR_LAMP_DRIVE_CONTROL   = 8'h74;
  localparam logic [7:0] ADDR_FUNCTION_ENABLE      = 8'h80;
  localparam logic [7:0] ADDR_AUX_PIN_CONTROL      = 8'hBE;

  // values after reset
  localparam logic [7:0] RST_SENSING_MODE_CONFIG  = 8'h00;
  localparam logic [7:0] RST_PHOTODIODE_PIN_ROUTE = 8'h00;
  localparam logic [7:0] RST_LAMP_DRIVE_CONTROL   = 8'h04;
  localparam logic [7:0] RST_FUNCTION_ENABLE      = 8'h00;
  localparam logic [3:0] RST_AUX_PIN_CONTROL      = 4'h2;

  // function enable fields
  localparam int POWER_ON_BIT_POS          = 0;
  localparam int SPECTRAL_MEASURE_EN_POS   = 1;
  localparam int WAIT_ENABLE_POS           = 3;
  localparam int CHANNEL_MUX_START_POS     = 4;
  localparam int FLICKER_DETECT_EN_POS     = 6;

  // sensing mode fields
  localparam int SENSE_MODE_LSB            = 0;
  localparam int SYNC_TO_IRQ_POS           = 2;
  localparam int LAMP_CONTROL_SELECT_POS   = 3;

  // photodiode routing fields
  localparam int PHOTODIODE_TO_IRQ_POS     = 0;
  localparam int PHOTODIODE_TO_AUX_POS     = 1;

  // aux pin control fields
  localparam int AUX_INPUT_LEVEL_POS       = 0;
  localparam int AUX_OUTPUT_STATE_POS      = 1;
  localparam int AUX_INPUT_ENABLE_POS      = 2;
  localparam int AUX_OUTPUT_INVERT_POS     = 3;

  // lamp fields
  localparam int LAMP_ON_POS               = 7;
  localparam int LAMP_DRIVE_MSB            = 6;

  // light sensing modes
  typedef enum logic [1:0]
  {
    NORMAL_SPECTRAL_MODE  = 2'h0,
    SYNC_START_MODE       = 2'h1,
    RESERVED_MODE         = 2'h2,
    SYNC_START_STOP_MODE  = 2'h3
  } sense_mode_e;

endpackage

// *** design/sensor_enable_config_bank.sv ***
`timescale 1ns/1ps

module sensor_enable_config_bank
(
  input  wire logic                      core_clk,
  input  wire logic                      nrst,
  input  wire logic                      clk_en,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [7:0]                reg_rdata,
  input  wire logic                      mux_done,
  input  wire logic                      sync_in,
  input  wire logic                      pd_aux_in,
  input  wire logic                      pd_irq_in,
  input  wire logic                      aux_pin_in,
  output logic                           aux_pin_out,
  output logic                           aux_pin_oe_n,
  output logic                           irq_pin_out,
  output logic                           lamp_driver_pin,
  output logic                           lamp_pin_oe_n,
  output logic      [6:0]                lamp_drive_current,
  output logic                           osc_enable,
  output logic                           spectral_measure_enable,
  output logic                           flicker_detect_enable,
  output logic                           wait_enable,
  output logic                           channel_mux_start,
  output logic                           mux_busy,
  output sensor_cfg_pkg::sense_mode_e    sense_mode
);
  import sensor_cfg_pkg::*;

  logic [7:0] function_enable_r;
  logic [7:0] sensing_mode_config_r;
  logic [7:0] photodiode_pin_route_r;
  logic [7:0] lamp_drive_control_r;
  logic [3:0] aux_pin_control_r;
  logic [7:0] rdata_nxt;
  logic       wr_en;
  logic       power_on_bit;
  logic       lamp_control_select;
  logic       aux_input_enable;
  logic       aux_level;

  assign wr_en               = clk_en & reg_wr;
  assign power_on_bit        = function_enable_r[POWER_ON_BIT_POS];
  assign lamp_control_select = sensing_mode_config_r[LAMP_CONTROL_SELECT_POS];
  assign aux_input_enable    = aux_pin_control_r[AUX_INPUT_ENABLE_POS];

  // function enable; the multiplexer start bit self-clears on completion,
  // but a fresh write of 1 in the same cycle as completion wins
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      function_enable_r <= RST_FUNCTION_ENABLE;
    end
    else if (clk_en)
    begin
      if (reg_wr && reg_addr == ADDR_FUNCTION_ENABLE)
      begin
        function_enable_r <= reg_wdata;
        if (!reg_wdata[CHANNEL_MUX_START_POS] && !mux_done)
        begin
          // a write of 0 cannot abort a running multiplexer command
          function_enable_r[CHANNEL_MUX_START_POS] <= function_enable_r[CHANNEL_MUX_START_POS];
        end
      end
      else if (mux_done)
      begin
        function_enable_r[CHANNEL_MUX_START_POS] <= 1'b0;
      end
    end
  end

  // sensing mode register, all bits stored as written
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sensing_mode_config_r <= RST_SENSING_MODE_CONFIG;
    end
    else if (wr_en && reg_addr == ADDR_SENSING_MODE_CONFIG)
    begin
      sensing_mode_config_r <= reg_wdata;
    end
  end

  // photodiode routing register
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      photodiode_pin_route_r <= RST_PHOTODIODE_PIN_ROUTE;
    end
    else if (wr_en && reg_addr == ADDR_PHOTODIODE_PIN_ROUTE)
    begin
      photodiode_pin_route_r <= reg_wdata;
    end
  end

  // lamp register, drive code defaults to 12 mA
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lamp_drive_control_r <= RST_LAMP_DRIVE_CONTROL;
    end
    else if (wr_en && reg_addr == ADDR_LAMP_DRIVE_CONTROL)
    begin
      lamp_drive_control_r <= reg_wdata;
    end
  end

  // aux pin control; bit 0 is the sampled input, never written by software
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aux_pin_control_r <= RST_AUX_PIN_CONTROL;
    end
    else if (clk_en)
    begin
      if (reg_wr && reg_addr == ADDR_AUX_PIN_CONTROL)
      begin
        aux_pin_control_r[AUX_OUTPUT_INVERT_POS:AUX_OUTPUT_STATE_POS] <=
          reg_wdata[AUX_OUTPUT_INVERT_POS:AUX_OUTPUT_STATE_POS];
      end
      // input reads as 0 while input mode is off, so stale levels never show
      aux_pin_control_r[AUX_INPUT_LEVEL_POS] <= aux_input_enable & aux_pin_in;
    end
  end

  // read mux; unmapped addresses and the upper four aux control bits read as zero, other registers return all eight stored bits
  always_comb
  begin
    rdata_nxt = 8'h00;
    unique case (reg_addr)
      ADDR_FUNCTION_ENABLE:      rdata_nxt = function_enable_r;
      ADDR_SENSING_MODE_CONFIG:  rdata_nxt = sensing_mode_config_r;
      ADDR_PHOTODIODE_PIN_ROUTE: rdata_nxt = photodiode_pin_route_r;
      ADDR_LAMP_DRIVE_CONTROL:   rdata_nxt = lamp_drive_control_r;
      ADDR_AUX_PIN_CONTROL:      rdata_nxt = {4'h0, aux_pin_control_r};
      default:                   rdata_nxt = 8'h00;
    endcase
  end

  // read data is held until the next read so the host can sample late
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata <= 8'h00;
    end
    else if (clk_en && reg_rd)
    begin
      reg_rdata <= rdata_nxt;
    end
  end

  // oscillator follows the power bit; clearing power stops the device
  // without losing the stored settings
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      osc_enable <= RST_FUNCTION_ENABLE[POWER_ON_BIT_POS];
    end
    else if (clk_en)
    begin
      osc_enable <= power_on_bit;
    end
  end

  // measurement enables are gated by power, so an enable bit left set
  // while power is off cannot start anything without an oscillator
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      spectral_measure_enable <= RST_FUNCTION_ENABLE[SPECTRAL_MEASURE_EN_POS];
      flicker_detect_enable   <= RST_FUNCTION_ENABLE[FLICKER_DETECT_EN_POS];
      wait_enable             <= RST_FUNCTION_ENABLE[WAIT_ENABLE_POS];
    end
    else if (clk_en)
    begin
      spectral_measure_enable <= power_on_bit & function_enable_r[SPECTRAL_MEASURE_EN_POS];
      flicker_detect_enable   <= power_on_bit & function_enable_r[FLICKER_DETECT_EN_POS];
      wait_enable             <= power_on_bit & function_enable_r[WAIT_ENABLE_POS];
    end
  end

  // multiplexer busy mirrors the start bit until completion clears it
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mux_busy <= RST_FUNCTION_ENABLE[CHANNEL_MUX_START_POS];
    end
    else if (clk_en)
    begin
      mux_busy <= function_enable_r[CHANNEL_MUX_START_POS];
    end
  end

  // sensing mode; the reserved code is passed on unchanged so the engine
  // decides what to do with it instead of a silent remap here
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sense_mode <= NORMAL_SPECTRAL_MODE;
    end
    else if (clk_en)
    begin
      sense_mode <= sense_mode_e'(sensing_mode_config_r[SENSE_MODE_LSB +: 2]);
    end
  end

  // one-cycle start pulse when software writes the multiplexer start bit
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      channel_mux_start <= 1'b0;
    end
    else if (clk_en)
    begin
      channel_mux_start <= reg_wr && reg_addr == ADDR_FUNCTION_ENABLE
                           && reg_wdata[CHANNEL_MUX_START_POS];
    end
  end

  // aux pin level: photodiode routing overrides the register-driven state
  always_comb
  begin
    aux_level = aux_pin_control_r[AUX_OUTPUT_STATE_POS];
    if (photodiode_pin_route_r[PHOTODIODE_TO_AUX_POS])
    begin
      aux_level = pd_aux_in;
    end
  end

  // aux pin level; inversion is applied last so it also flips a routed
  // photodiode signal, which keeps one polarity control for both sources
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aux_pin_out <= RST_AUX_PIN_CONTROL[AUX_OUTPUT_STATE_POS];
    end
    else if (clk_en)
    begin
      aux_pin_out <= aux_level ^ aux_pin_control_r[AUX_OUTPUT_INVERT_POS];
    end
  end

  // aux driver releases the pin while input mode is on, so an external
  // source never fights the output stage
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aux_pin_oe_n <= RST_AUX_PIN_CONTROL[AUX_INPUT_ENABLE_POS];
    end
    else if (clk_en)
    begin
      aux_pin_oe_n <= aux_input_enable;
    end
  end

  // interrupt pin; sync routing takes priority over the photodiode on the
  // shared pin, and with neither routed the pin rests low
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_pin_out <= 1'b0;
    end
    else if (clk_en)
    begin
      if (sensing_mode_config_r[SYNC_TO_IRQ_POS])
      begin
        irq_pin_out <= sync_in;
      end
      else
      begin
        irq_pin_out <= photodiode_pin_route_r[PHOTODIODE_TO_IRQ_POS] & pd_irq_in;
      end
    end
  end

  // lamp pin is released entirely when the lamp select bit is clear; the on
  // level is held low meanwhile so a driver that ignores the enable stays off
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lamp_driver_pin <= 1'b0;
      lamp_pin_oe_n   <= ~RST_SENSING_MODE_CONFIG[LAMP_CONTROL_SELECT_POS];
    end
    else if (clk_en)
    begin
      lamp_pin_oe_n   <= ~lamp_control_select;
      lamp_driver_pin <= lamp_control_select & lamp_drive_control_r[LAMP_ON_POS];
    end
  end

  // drive code always mirrors the register; it only takes effect once the
  // lamp pin is under control, so gating it here would add nothing
  // (limitation: the code is not checked against the driver's rating)
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lamp_drive_current <= RST_LAMP_DRIVE_CONTROL[LAMP_DRIVE_MSB:0];
    end
    else if (clk_en)
    begin
      lamp_drive_current <= lamp_drive_control_r[LAMP_DRIVE_MSB:0];
    end
  end

endmodule // sensor_enable_config_bank

// *** sim/host_model.sv ***
`timescale 1ns/1ps
module host_model
(
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  // bus idles low until the first request
  initial
  begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  end

  // one-cycle strobe; released lines flip so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
  endtask

  // read data is registered and stands, so it is taken after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge core_clk);
    {reg_addr, reg_rd} = {~a, 1'b0};
    d = reg_rdata;
  endtask
endmodule // host_model

// *** sim/cfg_bank_assertions.sv ***
`timescale 1ns/1ps
module cfg_bank_checker
(
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       mux_done,
  input wire logic       sync_in,
  input wire logic       irq_pin_out,
  input wire logic       lamp_driver_pin,
  input wire logic       lamp_pin_oe_n,
  input wire logic [6:0] lamp_drive_current,
  input wire logic       osc_enable,
  input wire logic       spectral_measure_enable,
  input wire logic       channel_mux_start,
  input wire logic       mux_busy
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  // accepted write to address a with all bits of m set
  sequence wr_s(logic [7:0] a, logic [7:0] m);
    clk_en && reg_wr && reg_addr == a && (reg_wdata & m) == m;
  endsequence

  // enabled edge without a write, so the stored value holds
  sequence hold_s;
    clk_en && !reg_wr;
  endsequence

  mux_pulse_a: assert property (wr_s(8'h80, 8'h10) |=> channel_mux_start)
    else $error("mux start pulse missing");
  mux_clear_a: assert property (clk_en && mux_done && !reg_wr ##1 clk_en |=> !mux_busy)
    else $error("mux busy not cleared");
  power_on_a: assert property (wr_s(8'h80, 8'h01) ##1 hold_s |=> osc_enable)
    else $error("oscillator not started");
  power_gate_a: assert property (spectral_measure_enable |-> osc_enable)
    else $error("measurement without power");
  irq_sync_a: assert property (wr_s(8'h70, 8'h04) ##1 hold_s |=> irq_pin_out == $past(sync_in))
    else $error("sync not on irq pin");
  lamp_off_a: assert property (lamp_pin_oe_n |-> !lamp_driver_pin)
    else $error("lamp driven while released");
  lamp_current_a: assert property (wr_s(8'h74, 8'h00) ##1 hold_s |=>
    {1'b0, lamp_drive_current} == ($past(reg_wdata, 2) & 8'h7F))
    else $error("lamp current wrong");
  unmapped_read_a: assert property (clk_en && reg_rd && !(reg_addr inside {8'h70, 8'h73, 8'h74, 8'h80, 8'hBE})
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // cfg_bank_checker

bind sensor_enable_config_bank cfg_bank_checker i_cfg_bank_checker (.*);

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb;
  import sensor_cfg_pkg::*;
  logic        core_clk, nrst, clk_en, mux_done, sync_in, pd_aux_in, pd_irq_in, aux_pin_in;
  logic        reg_wr, reg_rd, aux_pin_out, aux_pin_oe_n, irq_pin_out, lamp_driver_pin, lamp_pin_oe_n;
  logic        osc_enable, spectral_measure_enable, flicker_detect_enable, wait_enable;
  logic        channel_mux_start, mux_busy;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rdv;
  logic [6:0]  lamp_drive_current;
  sense_mode_e sense_mode;
  int          fails;
  int          check_count;
  logic [7:0]  raddr [6] = '{8'h70, 8'h73, 8'h74, 8'h80, 8'hBE, 8'h71};
  logic [7:0]  rrst [6] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h02, 8'h00};

  sensor_enable_config_bank i_sensor_enable_config_bank (.*);
  host_model i_host_model (.*);

  // free-running core clock
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic test_done();
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host_model.wr(a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    i_host_model.rd(a, rdv);
    chk(rdv, exp);
  endtask

  // derived outputs lag a write by two edges
  task automatic settle();
    repeat (2) @(negedge core_clk);
  endtask

  // main sequence; clk_en and the photodiode inputs are toggled on purpose
  initial
  begin
    {nrst, clk_en, mux_done, sync_in, pd_aux_in, pd_irq_in, aux_pin_in} = 7'h20;
    repeat (20) @(negedge core_clk);
    nrst = 1'b1;
    foreach (raddr[i]) rc(raddr[i], rrst[i]);
    chk(8'(lamp_pin_oe_n), 8'h01);
    chk(8'(aux_pin_out), 8'h01);
    wr(8'h80, 8'h01);
    settle();
    chk(8'(osc_enable), 8'h01);
    chk(8'(spectral_measure_enable), 8'h00);
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h70, 8'(m));
      settle();
      chk({6'h00, sense_mode}, 8'(m));
    end
    // sync-start-stop results live outside this bank, so that range reads zero
    rc(8'h60, 8'h00);
    wr(8'h70, 8'h0C);
    wr(8'h74, 8'h85);
    sync_in = 1'b1;
    settle();
    chk(8'(lamp_driver_pin), 8'h01);
    chk(8'(lamp_pin_oe_n), 8'h00);
    chk(8'(lamp_drive_current), 8'h05);
    chk(8'(irq_pin_out), 8'h01);
    sync_in = 1'b0;
    wr(8'h70, 8'h08);
    wr(8'h73, 8'h01);
    pd_irq_in = 1'b1;
    settle();
    chk(8'(irq_pin_out), 8'h01);
    rc(8'h73, 8'h01);
    // aux routing replaces the register level; irq routing is dropped
    wr(8'h73, 8'h02);
    settle();
    chk(8'(aux_pin_out), 8'h00);
    chk(8'(irq_pin_out), 8'h00);
    pd_aux_in = 1'b1;
    settle();
    chk(8'(aux_pin_out), 8'h01);
    wr(8'h73, 8'h00);
    wr(8'hBE, 8'h08);
    settle();
    chk(8'(aux_pin_out), 8'h01);
    wr(8'hBE, 8'h00);
    settle();
    chk(8'(aux_pin_out), 8'h00);
    wr(8'hBE, 8'h02);
    settle();
    chk(8'(aux_pin_out), 8'h01);
    wr(8'hBE, 8'h04);
    aux_pin_in = 1'b1;
    settle();
    chk(8'(aux_pin_oe_n), 8'h01);
    rc(8'hBE, 8'h05);
    // lamp select clear hands the lamp back: pin released, driver low
    wr(8'h70, 8'h00);
    settle();
    chk(8'(lamp_pin_oe_n), 8'h01);
    chk(8'(lamp_driver_pin), 8'h00);
    // clock enable low: a write must not land
    clk_en = 1'b0;
    wr(8'h74, 8'h00);
    clk_en = 1'b1;
    rc(8'h74, 8'h85);
    // spectral enable comes last, after power and configuration
    wr(8'h80, 8'h4B);
    settle();
    chk(8'({flicker_detect_enable, wait_enable, spectral_measure_enable}), 8'h07);
    wr(8'h80, 8'h5B);
    chk(8'(channel_mux_start), 8'h01);
    @(negedge core_clk);
    chk(8'(channel_mux_start), 8'h00);
    wr(8'h80, 8'h4B);
    rc(8'h80, 8'h5B);
    chk(8'(mux_busy), 8'h01);
    mux_done = 1'b1;
    @(negedge core_clk);
    mux_done = 1'b0;
    settle();
    rc(8'h80, 8'h4B);
    chk(8'(mux_busy), 8'h00);
    wr(8'h80, 8'h4A);
    settle();
    chk(8'({osc_enable, spectral_measure_enable}), 8'h00);
    rc(8'h80, 8'h4A);
    test_done();
  end

  // watchdog: the sequence needs about 125 cycles
  initial
  begin
    repeat (5000) @(posedge core_clk);
    fails++;
    test_done();
  end
endmodule // tb
